// File: design/tmc_consts.svh
/*
 Constants for the compact 8-bit core and its fabric partner.
 Assumes inclusion by bare name from the design files.
*/
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// ==========================================
// Core
`define TMC_IRQ_VECTOR 10'h3ff
`define TMC_RESET_PC 10'h000
`define TMC_STACK_DEPTH 31
`define TMC_RST_FLAG 1'b0

// ==========================================
// Fabric register map, byte addresses
`define TMC_CTRL_OFS 8'h00
`define TMC_IN_DATA_OFS 8'h04
`define TMC_OUT_SEL_OFS 8'h08
`define TMC_OUT_DATA_OFS 8'h0c
`define TMC_RD_COUNT_OFS 8'h10
`define TMC_CTRL_IRQ_BIT 0
`define TMC_CTRL_RST_BIT 1
`define TMC_IN_DATA_RST 8'h00
`define TMC_OUT_SEL_RST 8'h00
`define TMC_RST_CYCLES 2'h2

`endif

// File: design/tmc_pkg.sv
/*
 Types shared by the core, the fabric end and the bench.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tmc_pkg;

	// ==========================================
	// Operations and conditions
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_ADD = 4'h1,
		add_with_carry_op = 4'h2,
		OP_AND = 4'h3,
		OP_CALL = 4'h4,
		OP_COMPARE = 4'h5,
		irq_disable_op = 4'h6,
		OP_IRQ_ENABLE = 4'h7,
		OP_INPUT = 4'h8,
		OP_OUTPUT = 4'h9
	} tmc_op_t;

	typedef enum logic [2:0] {
		COND_ALWAYS = 3'h0,
		COND_C = 3'h1,
		COND_NC = 3'h2,
		COND_Z = 3'h3,
		COND_NZ = 3'h4
	} tmc_cond_t;

	typedef struct packed {
		tmc_op_t op;
		tmc_cond_t cond;
		logic [3:0] dest_register;
		logic [3:0] source_register;
		logic use_imm;
		logic [7:0] immediate_byte;
		logic [9:0] target;
	} tmc_instr_t;

	// ==========================================
	// Core sequencing, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_EXEC1 = 5'b00010,
		ST_EXEC2 = 5'b00100,
		ST_INT1 = 5'b01000,
		ST_INT2 = 5'b10000
	} tmc_state_t;

endpackage

// File: design/tmc_port_if.sv
/*
 Link between the core and the fabric logic around it.
 Assumes both ends share clk; all signals are plain levels.
*/
`timescale 1ns/10ps
interface tmc_port_if;
	logic [7:0] in_data;
	logic irq;
	logic rst_req;
	logic [7:0] out_data;
	logic [7:0] io_port_address;
	logic in_taken;
	logic out_valid;
	logic irq_ack;

	modport core
	(
		input in_data,
		input irq,
		input rst_req,
		output out_data,
		output io_port_address,
		output in_taken,
		output out_valid,
		output irq_ack
	);

	modport fabric
	(
		output in_data,
		output irq,
		output rst_req,
		input out_data,
		input io_port_address,
		input in_taken,
		input out_valid,
		input irq_ack
	);
endinterface

// File: design/tmc_stack.sv
/*
 Cyclic return-address stack; the oldest entry is overwritten when full.
 Assumes push and clear come from logic on the same clock.
*/
`timescale 1ns/10ps
`include "tmc_consts.svh"
module tmc_stack #(
	parameter int DEPTH = `TMC_STACK_DEPTH,
	parameter int WIDTH = 10
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic push,
	input wire logic clear,
	input wire logic [WIDTH-1:0] push_data,
	output logic [WIDTH-1:0] stack_top,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	import tmc_pkg::*;
	localparam int PW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] ptr;
		logic [LW-1:0] level;
	} tmc_stack_state_t;

	tmc_stack_state_t s_reg;
	tmc_stack_state_t s_next;

	// ==========================================
	// Next state
	always_comb
	begin
		s_next = s_reg;
		if (clear)
		begin
			s_next.ptr = '0;
			s_next.level = '0;
		end
		else if (push)
		begin
			// Wrap keeps the newest 31 entries, losing the oldest
			if (s_reg.ptr == PW'(DEPTH - 1))
				s_next.ptr = '0;
			else
				s_next.ptr = s_reg.ptr + 1'b1;
			s_next.mem[s_next.ptr] = push_data;
			if (s_reg.level != LW'(DEPTH))
				s_next.level = s_reg.level + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign stack_top = s_reg.mem[s_reg.ptr];
	assign level = s_reg.level;
endmodule

// File: design/tmc_core.sv
/*
 Compact 8-bit core: port sequencing, interrupt event, add, add with carry,
 and, call, compare, interrupt enable and disable.
 Assumes instructions are offered on a valid/ready port for the address on pc,
 and that the fabric end drives the link on the same clock.
*/
// Implementation choices: register access over APB and the placing of the registers.
// Behaviour
// - Input bus sampled into destination at edge
// - Source holds interrupt high two cycles minimum
// - Interrupt ignored while allow flag cleared
// - Reset input high forces reset event
// - Reset event generated automatically after configuration
// - All storage updates on rising clock edge
// - Output byte held two cycles
// - Port address driven two cycles for I/O
// - Input taken pulses in second input cycle
// - Output valid pulses in second output cycle
// - Fabric latches output when output valid high; this fabric latches only when the port address equals out_sel
// - Interrupt acknowledge in second interrupt event cycle
// - Fabric clears source on ack, pops on taken; this fabric pops nothing and only increments rd_count on taken
// - Add writes sum, updates zero and carry
// - Add with carry includes carry in sum
// - And writes result, zero updated, carry cleared
// - Call pushes pc, loads target address
// - Conditional call only when condition holds
// - Compare sets flags, leaves registers unchanged
// - Interrupt saves flags, disables, pushes, vectors
// - Reset clears pc, flags, allow, stack only
// - Stack holds 31 entries, cyclic overwrite
`timescale 1ns/10ps
`include "tmc_consts.svh"
module tmc_core #(
	parameter int STACK_DEPTH = `TMC_STACK_DEPTH
)
(
	input wire logic clk,
	input wire logic nrst,
	tmc_port_if.core link,
	input wire logic instr_valid,
	input wire tmc_pkg::tmc_instr_t instr,
	output logic instr_ready,
	output logic [9:0] pc,
	output logic flag_zero,
	output logic flag_carry,
	output logic irq_allow,
	input wire logic [3:0] reg_sel,
	output logic [7:0] reg_value,
	output logic [$clog2(STACK_DEPTH+1)-1:0] stack_level
);
	import tmc_pkg::*;

	typedef struct packed {
		tmc_state_t state;
		tmc_instr_t cur;
		logic [9:0] pc;
		logic zero;
		logic carry;
		logic allow;
		logic saved_zero;
		logic saved_carry;
		logic [15:0][7:0] regs;
		logic [7:0] port_addr;
		logic [7:0] out_data;
		logic por;
		logic irq_held;
	} tmc_core_state_t;

	tmc_core_state_t s_reg;
	tmc_core_state_t s_next;
	logic push;
	logic clear;
	logic [9:0] push_data;
	logic reset_event;
	logic take_irq;
	logic cond_ok;
	logic [7:0] dval;
	logic [7:0] opnd;
	logic [8:0] sum;
	logic [7:0] res;

	// ==========================================
	// Return stack
	tmc_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(10)
	) u_stack (
		.clk(clk),
		.nrst(nrst),
		.push(push),
		.clear(clear),
		.push_data(push_data),
		.stack_top(),
		.level(stack_level)
	);

	// ==========================================
	// Decode helpers
	assign reset_event = link.rst_req || s_reg.por;
	// Interrupts are only taken between instructions; a request seen
	// mid-instruction is held so a two-cycle pulse is not lost
	assign take_irq = s_reg.allow && (link.irq || s_reg.irq_held);
	assign dval = s_reg.regs[s_reg.cur.dest_register];
	assign opnd = s_reg.cur.use_imm ? s_reg.cur.immediate_byte
		: s_reg.regs[s_reg.cur.source_register];

	always_comb
	begin
		case (s_reg.cur.cond)
			COND_ALWAYS: cond_ok = 1'b1;
			COND_C: cond_ok = s_reg.carry;
			COND_NC: cond_ok = !s_reg.carry;
			COND_Z: cond_ok = s_reg.zero;
			COND_NZ: cond_ok = !s_reg.zero;
			default: cond_ok = 1'b0;
		endcase
	end

	// ==========================================
	// Next state
	always_comb
	begin
		s_next = s_reg;
		push = 1'b0;
		clear = 1'b0;
		push_data = s_reg.pc;
		sum = 9'h000;
		res = 8'h00;
		// Dropping the allow flag drops a held request too
		s_next.irq_held = s_reg.allow && (s_reg.irq_held || link.irq);
		if (reset_event)
		begin
			// Data registers deliberately survive a reset event
			s_next.state = ST_IDLE;
			s_next.pc = `TMC_RESET_PC;
			s_next.zero = `TMC_RST_FLAG;
			s_next.carry = `TMC_RST_FLAG;
			s_next.allow = `TMC_RST_FLAG;
			s_next.por = 1'b0;
			s_next.irq_held = 1'b0;
			clear = 1'b1;
		end
		else
		begin
			case (s_reg.state)
				ST_IDLE:
				begin
					if (take_irq)
						s_next.state = ST_INT1;
					else if (instr_valid)
					begin
						s_next.state = ST_EXEC1;
						s_next.cur = instr;
						if (instr.op == OP_INPUT || instr.op == OP_OUTPUT)
						begin
							s_next.port_addr = instr.use_imm ? instr.immediate_byte
								: s_reg.regs[instr.source_register];
							s_next.out_data = s_reg.regs[instr.dest_register];
						end
					end
				end
				ST_EXEC1:
					s_next.state = ST_EXEC2;
				ST_EXEC2:
				begin
					s_next.state = ST_IDLE;
					s_next.pc = s_reg.pc + 10'h001;
					case (s_reg.cur.op)
						OP_ADD, add_with_carry_op:
						begin
							sum = {1'b0, dval} + {1'b0, opnd};
							if (s_reg.cur.op == add_with_carry_op)
								sum = sum + {8'h00, s_reg.carry};
							s_next.regs[s_reg.cur.dest_register] = sum[7:0];
							s_next.zero = (sum[7:0] == 8'h00);
							s_next.carry = sum[8];
						end
						OP_AND:
						begin
							res = dval & opnd;
							s_next.regs[s_reg.cur.dest_register] = res;
							s_next.zero = (res == 8'h00);
							s_next.carry = 1'b0;
						end
						OP_CALL:
						begin
							if (cond_ok)
							begin
								push = 1'b1;
								s_next.pc = s_reg.cur.target;
							end
						end
						OP_COMPARE:
						begin
							s_next.zero = (dval == opnd);
							s_next.carry = (dval < opnd);
						end
						irq_disable_op:
							s_next.allow = 1'b0;
						OP_IRQ_ENABLE:
							s_next.allow = 1'b1;
						OP_INPUT:
							s_next.regs[s_reg.cur.dest_register] = link.in_data;
						default:
							s_next.pc = s_reg.pc + 10'h001;
					endcase
				end
				ST_INT1:
				begin
					s_next.state = ST_INT2;
					s_next.saved_zero = s_reg.zero;
					s_next.saved_carry = s_reg.carry;
					s_next.allow = 1'b0;
				end
				ST_INT2:
				begin
					s_next.state = ST_IDLE;
					push = 1'b1;
					s_next.pc = `TMC_IRQ_VECTOR;
				end
				default:
					s_next.state = ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_reg <= '0;
			s_reg.state <= ST_IDLE;
			s_reg.por <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	// ==========================================
	// Outputs
	// Idle takes an interrupt first, so a new instruction waits for it
	assign instr_ready = (s_reg.state == ST_IDLE) && !reset_event && !take_irq;
	assign pc = s_reg.pc;
	assign flag_zero = s_reg.zero;
	assign flag_carry = s_reg.carry;
	assign irq_allow = s_reg.allow;
	assign reg_value = s_reg.regs[reg_sel];
	assign link.io_port_address = s_reg.port_addr;
	assign link.out_data = s_reg.out_data;
	assign link.in_taken = !reset_event && (s_reg.state == ST_EXEC2)
		&& (s_reg.cur.op == OP_INPUT);
	assign link.out_valid = !reset_event && (s_reg.state == ST_EXEC2)
		&& (s_reg.cur.op == OP_OUTPUT);
	assign link.irq_ack = !reset_event && (s_reg.state == ST_INT2);
endmodule

// File: design/tmc_fabric.sv
/*
 Fabric end of the core link with an APB slave for software.
 Assumes APB3 signalling on clk; the slave answers with no wait states.
*/
`timescale 1ns/10ps
`include "tmc_consts.svh"
module tmc_fabric
(
	input wire logic clk,
	input wire logic nrst,
	tmc_port_if.fabric link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import tmc_pkg::*;

	typedef struct packed {
		logic irq_pending;
		logic [1:0] rst_cnt;
		logic [7:0] in_data;
		logic [7:0] out_sel;
		logic [7:0] out_latch;
		logic [7:0] rd_count;
		logic [31:0] prdata;
	} tmc_fab_state_t;

	tmc_fab_state_t s_reg;
	tmc_fab_state_t s_next;
	logic mapped;
	logic wr;

	// ==========================================
	// Decode
	always_comb
	begin
		case (paddr)
			`TMC_CTRL_OFS, `TMC_IN_DATA_OFS, `TMC_OUT_SEL_OFS,
			`TMC_OUT_DATA_OFS, `TMC_RD_COUNT_OFS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign wr = psel && penable && pwrite;

	// ==========================================
	// Next state
	always_comb
	begin
		s_next = s_reg;
		if (link.irq_ack)
			s_next.irq_pending = 1'b0;
		if (link.in_taken)
			s_next.rd_count = s_reg.rd_count + 8'h01;
		if (link.out_valid && link.io_port_address == s_reg.out_sel)
			s_next.out_latch = link.out_data;
		if (s_reg.rst_cnt != 2'h0)
			s_next.rst_cnt = s_reg.rst_cnt - 2'h1;
		if (wr)
		begin
			case (paddr)
				`TMC_CTRL_OFS:
				begin
					// A raise wins over an acknowledge in the same cycle
					if (pwdata[`TMC_CTRL_IRQ_BIT])
						s_next.irq_pending = 1'b1;
					if (pwdata[`TMC_CTRL_RST_BIT])
						s_next.rst_cnt = `TMC_RST_CYCLES;
				end
				`TMC_IN_DATA_OFS: s_next.in_data = pwdata[7:0];
				`TMC_OUT_SEL_OFS: s_next.out_sel = pwdata[7:0];
				default: s_next.in_data = s_reg.in_data;
			endcase
		end
		// Read data is captured in setup so it comes from a flip-flop
		if (psel && !penable)
		begin
			case (paddr)
				`TMC_CTRL_OFS: s_next.prdata = {30'h0, s_reg.rst_cnt != 2'h0, s_reg.irq_pending};
				`TMC_IN_DATA_OFS: s_next.prdata = {24'h0, s_reg.in_data};
				`TMC_OUT_SEL_OFS: s_next.prdata = {24'h0, s_reg.out_sel};
				`TMC_OUT_DATA_OFS: s_next.prdata = {24'h0, s_reg.out_latch};
				`TMC_RD_COUNT_OFS: s_next.prdata = {24'h0, s_reg.rd_count};
				default: s_next.prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_reg <= '0;
			s_reg.in_data <= `TMC_IN_DATA_RST;
			s_reg.out_sel <= `TMC_OUT_SEL_RST;
		end
		else
			s_reg <= s_next;
	end

	// ==========================================
	// Outputs
	assign link.in_data = s_reg.in_data;
	assign link.irq = s_reg.irq_pending;
	assign link.rst_req = (s_reg.rst_cnt != 2'h0);
	assign prdata = s_reg.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
endmodule

// File: test/tmc_monitor.sv
/*
 Checker on the link signals between core and fabric end.
 Assumes tb instantiates it beside the link, on clk and nrst.
*/
`timescale 1ns/10ps
module tmc_monitor
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] in_data,
	input wire logic irq,
	input wire logic rst_req,
	input wire logic [7:0] out_data,
	input wire logic [7:0] io_port_address,
	input wire logic in_taken,
	input wire logic out_valid,
	input wire logic irq_ack
);
	// ==========================================
	// Link timing
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	property p_one_strobe;
		$onehot0({in_taken, out_valid, irq_ack});
	endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("two link strobes at once");
	property p_addr_two;
		(in_taken || out_valid) |-> $stable(io_port_address);
	endproperty
	a_addr_two: assert property (p_addr_two)
		else $error("port address moved during transfer");
	property p_data_two;
		out_valid |-> $stable(out_data) ##1 $stable(out_data);
	endproperty
	a_data_two: assert property (p_data_two)
		else $error("output byte not held");
	property p_gap;
		(in_taken || out_valid) |=> !(in_taken || out_valid) [*2];
	endproperty
	a_gap: assert property (p_gap)
		else $error("strobes too close");
	property p_ack;
		irq_ack |-> irq && $past(irq);
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack without held request");
	property p_ack_clear;
		irq_ack |=> !irq && !irq_ack;
	endproperty
	a_ack_clear: assert property (p_ack_clear)
		else $error("request not cleared by ack");
	property p_irq_hold;
		$rose(irq) |=> irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("request shorter than two cycles");
	property p_rst_len;
		$rose(rst_req) |=> rst_req ##1 !rst_req;
	endproperty
	a_rst_len: assert property (p_rst_len)
		else $error("reset request length wrong");
	property p_rst_quiet;
		rst_req |-> !(in_taken || out_valid || irq_ack);
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("strobe during reset event");
	c_in: cover property (in_taken);
	c_out: cover property (out_valid);
	c_ack: cover property (irq_ack);
endmodule

// File: test/tb.sv
/*
 Self-checking bench: core and fabric end joined by the link.
 Assumes the fabric register map and link timing of the design.
*/
`timescale 1ns/10ps
`include "tmc_consts.svh"
module tb;
	import tmc_pkg::*;
	logic clk, nrst, instr_valid, psel, penable, pwrite, er;
	logic instr_ready, flag_zero, flag_carry, irq_allow, pready, pslverr;
	tmc_instr_t instr;
	logic [9:0] pc;
	logic [3:0] reg_sel;
	logic [7:0] reg_value, paddr;
	logic [4:0] stack_level;
	logic [31:0] pwdata, prdata, rd;
	int n_mismatch, n_checks, r[16], mpc, lvl, ind, i;
	bit z, c, ie, pend;
	tmc_op_t ops[5] = '{OP_ADD, add_with_carry_op, OP_AND, OP_COMPARE, OP_CALL};
	tmc_port_if link ();
	tmc_core tmc_core_i (.clk(clk), .nrst(nrst), .link(link), .instr_valid(instr_valid),
		.instr(instr), .instr_ready(instr_ready), .pc(pc), .flag_zero(flag_zero),
		.flag_carry(flag_carry), .irq_allow(irq_allow), .reg_sel(reg_sel),
		.reg_value(reg_value), .stack_level(stack_level));
	tmc_fabric tmc_fabric_i (.clk(clk), .nrst(nrst), .link(link), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	tmc_monitor tmc_monitor_i (.clk(clk), .nrst(nrst), .in_data(link.in_data),
		.irq(link.irq), .rst_req(link.rst_req), .out_data(link.out_data),
		.io_port_address(link.io_port_address), .in_taken(link.in_taken),
		.out_valid(link.out_valid), .irq_ack(link.irq_ack));
	// ==========================================
	// Clock and tasks
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	// Model commits after the core is idle again, interrupt included
	task exec(input tmc_op_t o, input tmc_cond_t cd, input logic [3:0] d,
		input logic [3:0] s, input logic im, input logic [7:0] k, input logic [9:0] t);
		int a, sum;
		a = im ? k : r[s];
		instr_valid <= 1;
		instr <= '{o, cd, d, s, im, k, t};
		reg_sel <= d;
		do @(posedge clk); while (instr_ready !== 1);
		instr_valid <= 0;
		do @(posedge clk); while (instr_ready !== 1);
		mpc = (mpc + 1) % 1024;
		case (o)
			OP_ADD, add_with_carry_op:
			begin
				sum = r[d] + a + ((o == add_with_carry_op) ? c : 0);
				r[d] = sum % 256;
				c = sum > 255;
				z = r[d] == 0;
			end
			OP_AND:
			begin
				r[d] = r[d] & a;
				z = r[d] == 0;
				c = 0;
			end
			OP_CALL:
				if (cd == COND_ALWAYS || (cd == COND_C && c) || (cd == COND_NC && !c)
					|| (cd == COND_Z && z) || (cd == COND_NZ && !z))
				begin
					mpc = t;
					lvl = (lvl < 31) ? lvl + 1 : 31;
				end
			OP_COMPARE:
			begin
				z = r[d] == a;
				c = r[d] < a;
			end
			irq_disable_op: ie = 0;
			OP_IRQ_ENABLE: ie = 1;
			OP_INPUT: r[d] = ind;
			default: ;
		endcase
		if (ie && pend)
		begin
			mpc = 10'h3ff;
			lvl = (lvl < 31) ? lvl + 1 : 31;
			ie = 0;
			pend = 0;
		end
		chk("pc", mpc, pc);
		chk("zero", z, flag_zero);
		chk("carry", c, flag_carry);
		chk("allow", ie, irq_allow);
		chk("level", lvl, stack_level);
		chk("reg", r[d], reg_value);
	endtask
	initial
	begin
		#2000000;
		n_mismatch++;
		close_out;
	end
	// ==========================================
	// Tests
	initial
	begin
		{nrst, instr_valid, instr, reg_sel, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(32'h501972b0));
		repeat (10) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		chk("por_ready", 0, instr_ready);
		@(posedge clk);
		chk("ready", 1, instr_ready);
		for (i = 0; i < 16; i++)
		begin
			ind = (i == 0) ? 8'h10 : $urandom % 256;
			apb(1, `TMC_IN_DATA_OFS, ind);
			exec(OP_INPUT, COND_ALWAYS, i, 0, 1, i, 0);
		end
		apb(0, `TMC_RD_COUNT_OFS, 0);
		chk("rd_count", 16, rd);
		$display("test input done");
		apb(1, `TMC_OUT_SEL_OFS, 8'h5a);
		exec(OP_OUTPUT, COND_ALWAYS, 3, 0, 1, 8'h5a, 0);
		apb(0, `TMC_OUT_DATA_OFS, 0);
		chk("out_data", r[3], rd);
		exec(OP_OUTPUT, COND_ALWAYS, 4, 0, 1, 8'h11, 0);
		apb(0, `TMC_OUT_DATA_OFS, 0);
		chk("out_other", r[3], rd);
		apb(0, 8'h20, 0);
		chk("slverr", 1, er);
		chk("unmapped", 0, rd);
		$display("test output done");
		apb(1, `TMC_CTRL_OFS, 1);
		pend = 1;
		exec(OP_ADD, COND_ALWAYS, 5, 6, 0, 0, 0);
		apb(0, `TMC_CTRL_OFS, 0);
		chk("pending", 1, rd[0]);
		exec(OP_IRQ_ENABLE, COND_ALWAYS, 0, 0, 1, 0, 0);
		apb(0, `TMC_CTRL_OFS, 0);
		chk("cleared", 0, rd[0]);
		exec(OP_IRQ_ENABLE, COND_ALWAYS, 0, 0, 1, 0, 0);
		exec(irq_disable_op, COND_ALWAYS, 0, 0, 1, 0, 0);
		$display("test interrupt done");
		for (i = 0; i < 10; i++)
		begin
			exec(OP_COMPARE, COND_ALWAYS, 0, 0, 1, 8'h10 + i / 5, 0);
			exec(OP_CALL, tmc_cond_t'(i % 5), 1, 0, 1, 0, $urandom % 1024);
		end
		$display("test call done");
		for (i = 0; i < 40; i++)
			exec(ops[$urandom % 5], tmc_cond_t'($urandom % 5), $urandom % 16, $urandom % 16,
				$urandom % 2, $urandom % 256, $urandom % 1024);
		for (i = 0; i < 32; i++)
			exec(OP_CALL, COND_ALWAYS, 2, 0, 1, 0, i * 3);
		$display("test random done");
		apb(1, `TMC_CTRL_OFS, 2);
		do @(posedge clk); while (instr_ready !== 1);
		chk("rst_pc", 0, pc);
		chk("rst_flags", 0, {flag_zero, flag_carry, irq_allow});
		chk("rst_level", 0, stack_level);
		chk("rst_reg", r[2], reg_value);
		$display("test reset done");
		close_out;
	end
endmodule
